/* File: core/lpi_link.sv */
// Function
// - Link drives 00 to hand the lines back when finished.
// - Link drives 01 to hold the lines while data is not ready.
// - Link drives 10 while sending data; never drives 11.
// - Link drives shared lines only after the physical layer grants them.
// - Only requests start from the link; the rest start from the physical layer.
// - Link sends a serial stream on its request line for bus or registers.
// - Every request stream starts with 1 and ends with 0.
// - Stream lengths: 7 bus, 9 register read, 17 register write.
// - Bus request: start, type bits 1-3, speed bits 4-5, stop at 6.
// - Read request: start, type bits 1-3, address bits 4-7, stop at 8.
// - Physical layers at 100 and 200 Mbit/s are supported.
// - Data path is 2 bits at 100 Mbit/s and 4 bits at 200.
// - Control width and interface clock do not change with speed.
// - Type codes 000 to 101 are used; 110 and 111 never sent.
// - Speed code 00 100, 01 200, 10 400 Mbit/s; 11 reserved.
// - Write request: type 1-3, address 4-7, data 8-15, stop at 16.
// - Fair or priority waits for idle; a receive loses it, reissue.
`timescale 1ns/100ps
`default_nettype none
module lpi_link (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration, high for a 100 Mbit/s physical layer
  input wire logic narrow_mode,
  // Request command, clk_sys domain
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [1:0] req_speed,
  input wire logic [3:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic req_done,
  output logic req_error,
  // Link pins, phy_clk domain
  input wire logic phy_clk,
  input wire logic [1:0] phy_link_control_pair_i,
  output logic [1:0] phy_link_control_pair_o,
  output logic phy_link_control_pair_oe,
  input wire logic [3:0] phy_data_i,
  output logic [3:0] phy_data_o,
  output logic [3:0] phy_data_oe,
  output logic link_request_line,
  // Outgoing packet nibbles, phy_clk domain
  input wire logic tx_valid,
  input wire logic [3:0] tx_data,
  input wire logic tx_keep,
  output logic tx_ready,
  // Incoming packet and status, phy_clk domain
  output logic rx_valid,
  output logic [3:0] rx_data,
  output logic status_valid,
  output logic [1:0] status_bits
);

  // ****************************************************
  // System side request holding
  // ****************************************************
  logic pend_q, pend_d;
  logic [2:0] kind_q, kind_d;
  logic [1:0] spd_q, spd_d;
  logic [3:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic tgl_q, tgl_d;
  logic ack_seen_q, ack_seen_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic ack_sync;
  logic bad_req;

  always_comb begin
    pend_d = pend_q;
    kind_d = kind_q;
    spd_d = spd_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    tgl_d = tgl_q;
    ack_seen_d = ack_seen_q;
    done_d = 1'b0;
    err_d = 1'b0;
    bad_req = (req_kind[2:1] == 2'h3) ||
              (!req_kind[2] && req_speed == lpi_pkg::SPD_RSV);
    if (pend_q && ack_sync != ack_seen_q) begin
      pend_d = 1'b0;
      ack_seen_d = ack_sync;
      done_d = 1'b1;
    end else if (req_valid && !pend_q) begin
      if (bad_req) begin
        err_d = 1'b1;
      end else begin
        // Fields stay frozen until the link side acknowledges
        kind_d = req_kind;
        spd_d = req_speed;
        addr_d = req_addr;
        wdata_d = req_wdata;
        tgl_d = ~tgl_q;
        pend_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_q <= 1'b0;
      kind_q <= 3'h0;
      spd_q <= 2'h0;
      addr_q <= 4'h0;
      wdata_q <= 8'h00;
      tgl_q <= 1'b0;
      ack_seen_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      kind_q <= kind_d;
      spd_q <= spd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      tgl_q <= tgl_d;
      ack_seen_q <= ack_seen_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  assign req_ready = !pend_q;
  assign req_done = done_q;
  assign req_error = err_q;

  // ****************************************************
  // Domain crossings
  // ****************************************************
  logic lrst, lnarrow, link_request_line_tgl;
  logic ack_tgl_q, ack_tgl_d;

  lpi_sync #(.W(3)) u_to_link (
    .clk(phy_clk),
    .d({rst, narrow_mode, tgl_q}),
    .q({lrst, lnarrow, link_request_line_tgl})
  );

  lpi_sync #(.W(1)) u_to_sys (
    .clk(clk_sys),
    .d(ack_tgl_q),
    .q(ack_sync)
  );

  // ****************************************************
  // Request stream assembly
  // ****************************************************
  logic [lpi_pkg::STREAM_W-1:0] stream;
  logic [4:0] stream_len;

  always_comb begin
    stream = '0;
    stream[lpi_pkg::POS_START] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      stream[lpi_pkg::POS_TYPE+i] = kind_q[2-i];
    end
    if (kind_q == lpi_pkg::K_REG_WRITE) begin
      for (int i = 0; i < 4; i++) begin
        stream[lpi_pkg::POS_ADDR+i] = addr_q[3-i];
      end
      for (int i = 0; i < 8; i++) begin
        stream[lpi_pkg::POS_DATA+i] = wdata_q[7-i];
      end
      stream_len = lpi_pkg::LEN_WRITE;
    end else if (kind_q == lpi_pkg::K_REG_READ) begin
      for (int i = 0; i < 4; i++) begin
        stream[lpi_pkg::POS_ADDR+i] = addr_q[3-i];
      end
      stream_len = lpi_pkg::LEN_READ;
    end else begin
      stream[lpi_pkg::POS_SPEED] = spd_q[1];
      stream[lpi_pkg::POS_SPEED+1] = spd_q[0];
      stream_len = lpi_pkg::LEN_BUS;
    end
    // Stop bit is the zero left above the last field
  end

  // ****************************************************
  // Link side state
  // ****************************************************
  lpi_pkg::lpi_lstate_t st_q, st_d;
  logic seen_q, seen_d;
  logic [2:0] lkind_q, lkind_d;
  logic [lpi_pkg::STREAM_W-1:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  logic link_request_line_q, link_request_line_d;
  logic [1:0] ctl_in_q;
  logic [3:0] din_q;
  logic [1:0] ctlo_q, ctlo_d;
  logic ctloe_q, ctloe_d;
  logic [3:0] dout_q, dout_d;
  logic [3:0] doe_q, doe_d;
  logic rxv_q, rxv_d;
  logic [3:0] rxd_q, rxd_d;
  logic stv_q, stv_d;
  logic [1:0] stb_q, stb_d;
  logic arb_kind;
  logic lost;
  logic [3:0] lanes;

  always_comb begin
    st_d = st_q;
    seen_d = seen_q;
    lkind_d = lkind_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    link_request_line_d = 1'b0;
    ctlo_d = ctlo_q;
    ctloe_d = ctloe_q;
    dout_d = dout_q;
    doe_d = doe_q;
    ack_tgl_d = ack_tgl_q;
    rxv_d = 1'b0;
    rxd_d = rxd_q;
    stv_d = 1'b0;
    stb_d = stb_q;
    lanes = lnarrow ? lpi_pkg::LANES_100 : lpi_pkg::LANES_200;
    arb_kind = (lkind_q == lpi_pkg::K_FAIR) ||
               (lkind_q == lpi_pkg::K_PRIORITY);
    lost = arb_kind && (ctl_in_q == lpi_pkg::CTL_RECEIVE);
    // Pins are read only while the physical layer owns them
    if (!ctloe_q) begin
      if (ctl_in_q == lpi_pkg::CTL_STATUS) begin
        stv_d = 1'b1;
        stb_d = din_q[1:0];
      end else if (ctl_in_q == lpi_pkg::CTL_RECEIVE) begin
        rxv_d = 1'b1;
        rxd_d = din_q & lanes;
      end
    end
    case (st_q)
      lpi_pkg::LS_IDLE: begin
        if (link_request_line_tgl != seen_q) begin
          seen_d = link_request_line_tgl;
          lkind_d = kind_q;
          sh_d = stream;
          cnt_d = stream_len;
          if (kind_q == lpi_pkg::K_FAIR || kind_q == lpi_pkg::K_PRIORITY) begin
            st_d = lpi_pkg::LS_WAIT_IDLE;
          end else begin
            st_d = lpi_pkg::LS_SHIFT;
          end
        end
      end
      lpi_pkg::LS_WAIT_IDLE: begin
        // Idle sampled last edge, so the start bit lands a clock later
        if (ctl_in_q == lpi_pkg::CTL_IDLE) begin
          st_d = lpi_pkg::LS_SHIFT;
        end
      end
      lpi_pkg::LS_SHIFT: begin
        if (lost) begin
          sh_d = stream;
          cnt_d = stream_len;
          st_d = lpi_pkg::LS_WAIT_IDLE;
        end else begin
          link_request_line_d = sh_q[0];
          sh_d = sh_q >> 1;
          cnt_d = cnt_q - 5'h01;
          if (cnt_q == 5'h01) begin
            if (lkind_q[2]) begin
              ack_tgl_d = ~ack_tgl_q;
              st_d = lpi_pkg::LS_IDLE;
            end else begin
              st_d = lpi_pkg::LS_WAIT_GRANT;
            end
          end
        end
      end
      lpi_pkg::LS_WAIT_GRANT: begin
        if (ctl_in_q == lpi_pkg::CTL_GRANT) begin
          ctlo_d = lpi_pkg::LNK_HOLD;
          ctloe_d = 1'b1;
          doe_d = lanes;
          dout_d = 4'h0;
          st_d = lpi_pkg::LS_OWN;
        end else if (lost) begin
          sh_d = stream;
          cnt_d = stream_len;
          st_d = lpi_pkg::LS_WAIT_IDLE;
        end
      end
      lpi_pkg::LS_OWN: begin
        if (tx_valid) begin
          ctlo_d = lpi_pkg::LNK_SEND;
          dout_d = tx_data & lanes;
        end else if (tx_keep) begin
          ctlo_d = lpi_pkg::LNK_HOLD;
          dout_d = 4'h0;
        end else begin
          ctlo_d = lpi_pkg::LNK_RELEASE;
          dout_d = 4'h0;
          st_d = lpi_pkg::LS_RELEASE;
        end
      end
      lpi_pkg::LS_RELEASE: begin
        // One clock of release code, then the lines float back
        ctloe_d = 1'b0;
        doe_d = 4'h0;
        ack_tgl_d = ~ack_tgl_q;
        st_d = lpi_pkg::LS_IDLE;
      end
      default: begin
        st_d = lpi_pkg::LS_IDLE;
        ctloe_d = 1'b0;
        doe_d = 4'h0;
      end
    endcase
  end

  // Control pair is two bits at every speed
  always_ff @(posedge phy_clk) begin
    ctl_in_q <= phy_link_control_pair_i;
    din_q <= phy_data_i;
    if (lrst) begin
      st_q <= lpi_pkg::LS_IDLE;
      seen_q <= 1'b0;
      lkind_q <= 3'h0;
      sh_q <= '0;
      cnt_q <= lpi_pkg::CNT_RST;
      link_request_line_q <= 1'b0;
      ctlo_q <= lpi_pkg::CTL_OUT_RST;
      ctloe_q <= 1'b0;
      dout_q <= 4'h0;
      doe_q <= 4'h0;
      ack_tgl_q <= 1'b0;
      rxv_q <= 1'b0;
      rxd_q <= 4'h0;
      stv_q <= 1'b0;
      stb_q <= 2'h0;
    end else begin
      st_q <= st_d;
      seen_q <= seen_d;
      lkind_q <= lkind_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      link_request_line_q <= link_request_line_d;
      ctlo_q <= ctlo_d;
      ctloe_q <= ctloe_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      ack_tgl_q <= ack_tgl_d;
      rxv_q <= rxv_d;
      rxd_q <= rxd_d;
      stv_q <= stv_d;
      stb_q <= stb_d;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign link_request_line = link_request_line_q;
  assign phy_link_control_pair_o = ctlo_q;
  assign phy_link_control_pair_oe = ctloe_q;
  assign phy_data_o = dout_q;
  assign phy_data_oe = doe_q;
  assign tx_ready = (st_q == lpi_pkg::LS_OWN);
  assign rx_valid = rxv_q;
  assign rx_data = rxd_q;
  assign status_valid = stv_q;
  assign status_bits = stb_q;

endmodule // lpi_link
`default_nettype wire

/* File: core/lpi_pkg.sv */
`default_nettype none
package lpi_pkg;

  // ****************************************************
  // Control pair, physical layer owns the lines
  // ****************************************************
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_GRANT = 2'h3;

  // ****************************************************
  // Control pair, link owns the lines
  // ****************************************************
  localparam logic [1:0] LNK_RELEASE = 2'h0;
  localparam logic [1:0] LNK_HOLD = 2'h1;
  localparam logic [1:0] LNK_SEND = 2'h2;

  // ****************************************************
  // Request type and speed codes
  // ****************************************************
  localparam logic [2:0] K_IMM_ACK = 3'h0;
  localparam logic [2:0] K_ISO = 3'h1;
  localparam logic [2:0] K_PRIORITY = 3'h2;
  localparam logic [2:0] K_FAIR = 3'h3;
  localparam logic [2:0] K_REG_READ = 3'h4;
  localparam logic [2:0] K_REG_WRITE = 3'h5;
  localparam logic [1:0] SPD_100 = 2'h0;
  localparam logic [1:0] SPD_200 = 2'h1;
  localparam logic [1:0] SPD_400 = 2'h2;
  localparam logic [1:0] SPD_RSV = 2'h3;

  // ****************************************************
  // Request stream layout
  // ****************************************************
  localparam int STREAM_W = 17;
  localparam int POS_START = 0;
  localparam int POS_TYPE = 1;
  localparam int POS_SPEED = 4;
  localparam int POS_ADDR = 4;
  localparam int POS_DATA = 8;
  localparam logic [4:0] LEN_BUS = 5'h07;
  localparam logic [4:0] LEN_READ = 5'h09;
  localparam logic [4:0] LEN_WRITE = 5'h11;

  // ****************************************************
  // Data path width, lane enables and sync depth
  // ****************************************************
  localparam int DATA_W = 4;
  localparam logic [3:0] LANES_200 = 4'hF;
  localparam logic [3:0] LANES_100 = 4'h3;
  localparam int SYNC_STAGES = 2;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [1:0] CTL_OUT_RST = 2'h0;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_WAIT_IDLE,
    LS_SHIFT,
    LS_WAIT_GRANT,
    LS_OWN,
    LS_RELEASE
  } lpi_lstate_t;

endpackage
`default_nettype wire

/* File: core/lpi_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module lpi_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk,
  // Bits from the other domain
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // No reset: the chain also carries the reset itself into this domain
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    q <= q_d;
  end

endmodule // lpi_sync
`default_nettype wire

/* File: testbench/lpi_link_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module lpi_link_chk (
  // System side
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic req_ready,
  input wire logic req_error,
  // Link side
  input wire logic phy_clk,
  input wire logic narrow_mode,
  input wire logic [1:0] phy_link_control_pair_i,
  input wire logic [1:0] phy_link_control_pair_o,
  input wire logic phy_link_control_pair_oe,
  input wire logic [3:0] phy_data_i,
  input wire logic [3:0] phy_data_oe,
  input wire logic tx_valid,
  input wire logic tx_keep,
  input wire logic tx_ready,
  input wire logic status_valid,
  input wire logic [1:0] status_bits
);
  // ****************
  // Pin ownership, status capture and request refusal
  // ****************
  property p_no_rsv;
    @(posedge phy_clk) disable iff (rst)
    phy_link_control_pair_oe |-> phy_link_control_pair_o != 2'h3;
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved pair value");
  property p_grant;
    @(posedge phy_clk) disable iff (rst)
    $rose(phy_link_control_pair_oe) |-> $past(phy_link_control_pair_i, 2) == 2'h3;
  endproperty
  a_grant: assert property (p_grant) else $error("drive without grant");
  property p_take;
    @(posedge phy_clk) disable iff (rst)
    $rose(phy_link_control_pair_oe) |-> phy_link_control_pair_o == 2'h1
      && phy_data_oe == (narrow_mode ? 4'h3 : 4'hF);
  endproperty
  a_take: assert property (p_take) else $error("bad first owned cycle");
  property p_send;
    @(posedge phy_clk) disable iff (rst)
    tx_ready && tx_valid |=> phy_link_control_pair_oe && phy_link_control_pair_o == 2'h2;
  endproperty
  a_send: assert property (p_send) else $error("no send code");
  property p_rel;
    @(posedge phy_clk) disable iff (rst)
    tx_ready && !tx_valid && !tx_keep |=> phy_link_control_pair_o == 2'h0 ##1 !phy_link_control_pair_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("bad release");
  property p_hold;
    @(posedge phy_clk) disable iff (rst)
    tx_ready && !tx_valid && tx_keep |=> phy_link_control_pair_oe && phy_link_control_pair_o == 2'h1;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold code");
  property p_quiet;
    @(posedge phy_clk) disable iff (rst)
    !phy_link_control_pair_oe && !$past(phy_link_control_pair_oe) |-> phy_data_oe == 4'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data driven unowned");
  property p_status;
    @(posedge phy_clk) disable iff (rst)
    phy_link_control_pair_i == 2'h1 && !phy_link_control_pair_oe
      |-> ##2 status_valid && status_bits == $past(phy_data_i[1:0], 2);
  endproperty
  a_status: assert property (p_status) else $error("status lost");
  property p_refuse;
    @(posedge clk_sys) disable iff (rst)
    req_valid && req_ready && req_kind[2:1] == 2'h3 |=> req_error && req_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("reserved kind taken");
endmodule // lpi_link_chk
bind lpi_link lpi_link_chk u_lpi_link_chk (
  .clk_sys, .rst, .req_valid, .req_kind, .req_ready, .req_error,
  .phy_clk, .narrow_mode, .phy_link_control_pair_i, .phy_link_control_pair_o,
  .phy_link_control_pair_oe, .phy_data_i, .phy_data_oe, .tx_valid, .tx_keep,
  .tx_ready, .status_valid, .status_bits
);
`default_nettype wire

/* File: testbench/lpi_phy_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lpi_phy_model (
  // Link clock and reset
  input wire logic phy_clk,
  input wire logic rst,
  // Scenario controls
  input wire logic rx_go,
  input wire logic slow,
  // Link pins
  input wire logic req_line,
  input wire logic link_oe,
  output logic [1:0] pair,
  output logic [3:0] lines,
  // Captured stream, length above bits
  output logic cap_stb,
  output logic [21:0] cap
);
  logic [16:0] b;
  logic [2:0] k;
  logic [1:0] sa;
  int n, len, st, cnt;
  bit pend, pst;
  // ****************
  // Same clock and pair width at either lane count
  // ****************
  always @(posedge phy_clk) begin
    cap_stb <= 1'b0;
    if (rst) begin
      n = 0;
      st = 0;
      pend = 0;
      pst = 0;
      pair <= 2'h0;
      lines <= 4'h0;
    end else begin
      if (st == 5) n = 0; // Requests heard during receive are dropped
      else if (n > 0 || req_line) begin
        if (n == 0) b = '0;
        b[n] = req_line;
        n++;
        k = {b[1], b[2], b[3]};
        len = (k == 3'h4) ? 9 : (k == 3'h5) ? 17 : 7;
        if (n > 3 && n == len) begin
          cap <= {5'(len), b};
          cap_stb <= 1'b1;
          n = 0;
          pend = !k[2];
          pst = (k == 3'h4);
          sa = {b[6], b[7]};
        end
      end
      // Status, receive and grant all start here, never at the link
      case (st)
        0: if (rx_go) begin
          st = 5;
          cnt = 4;
          pend = 0;
        end else if (pst) begin
          st = 4;
          pst = 0;
        end else if (pend) begin
          st = 7;
          cnt = slow ? 6 : 1;
          pend = 0;
        end
        2: if (link_oe) st = 3;
        3: if (!link_oe) st = 0;
        4: st = 0;
        5: if (--cnt == 0) begin
          st = 6;
          cnt = 2;
        end
        6: if (--cnt == 0) st = 0;
        7: if (--cnt == 0) st = 2;
        default: st = 0;
      endcase
      pair <= (st == 2) ? 2'h3 : (st == 4) ? 2'h1 : (st == 5) ? 2'h2 : 2'h0;
      // Undriven lines wander so a stale value is never read as good
      lines <= (st == 4) ? {~sa, sa} : lines + 4'h5;
    end
  end
endmodule // lpi_phy_model
`default_nettype wire

/* File: testbench/tb_link_to_phy_interface.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_link_to_phy_interface;
  logic clk_sys, rst, narrow_mode, req_valid, req_ready, req_done, req_error;
  logic [2:0] req_kind;
  logic [1:0] req_speed, phy_link_control_pair_i, phy_link_control_pair_o, pair, status_bits;
  logic [3:0] req_addr, phy_data_i, phy_data_o, phy_data_oe, lines, tx_data, rx_data;
  logic [7:0] req_wdata;
  logic phy_clk, phy_link_control_pair_oe, link_request_line, tx_valid, tx_keep, tx_ready;
  logic rx_valid, status_valid, rx_go, slow, cap_stb;
  logic [21:0] cap;
  logic [21:0] q_cap[$];
  logic [1:0] q_st[$];
  logic [3:0] q_rx[$];
  logic [3:0] tx_exp, lane_mask;
  bit tx_exp_v;
  integer seed = 32'h8035;
  int failures, checked;
  assign phy_link_control_pair_i = phy_link_control_pair_oe ? phy_link_control_pair_o : pair;
  assign phy_data_i = (phy_data_oe & phy_data_o) | (~phy_data_oe & lines);
  assign lane_mask = narrow_mode ? 4'h3 : 4'hF;
  lpi_link dut (.clk_sys, .rst, .narrow_mode, .req_valid, .req_kind, .req_speed, .req_addr,
    .req_wdata, .req_ready, .req_done, .req_error, .phy_clk, .phy_link_control_pair_i,
    .phy_link_control_pair_o, .phy_link_control_pair_oe, .phy_data_i, .phy_data_o, .phy_data_oe,
    .link_request_line, .tx_valid, .tx_data, .tx_keep, .tx_ready, .rx_valid, .rx_data,
    .status_valid, .status_bits);
  lpi_phy_model u_phy (.phy_clk, .rst, .rx_go, .slow, .req_line(link_request_line),
    .link_oe(phy_link_control_pair_oe), .pair, .lines, .cap_stb, .cap);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    phy_clk = 1'b0;
    #13;
    forever #32 phy_clk = ~phy_clk;
  end
  // ****************
  // Link-side traffic and capture
  // ****************
  always @(posedge phy_clk) begin
    if (cap_stb) q_cap.push_back(cap);
    if (status_valid === 1'b1) q_st.push_back(status_bits);
    // Receive nibbles are expected two clocks after the pins show them
    if (rx_valid === 1'b1) chk("rx data", q_rx.size() ? 22'(q_rx.pop_front()) : 22'h3FFFFF, 22'(rx_data));
    if (phy_link_control_pair_oe === 1'b0 && phy_link_control_pair_i === 2'h2) q_rx.push_back(phy_data_i & lane_mask);
    if (tx_exp_v) chk("tx data", 22'(tx_exp), 22'(phy_data_o));
    tx_exp_v = tx_ready === 1'b1 && tx_valid === 1'b1;
    tx_exp = tx_data & lane_mask;
    #1;
    {tx_valid, tx_keep, tx_data} = 6'($random(seed));
  end
  task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_req(input logic [2:0] k, input logic [1:0] s);
    logic [3:0] a;
    logic [7:0] w;
    logic [21:0] e;
    bit bad;
    int t;
    a = 4'($random(seed));
    w = 8'($random(seed));
    bad = k[2:1] == 2'h3 || (!k[2] && s == 2'h3);
    e = '0;
    e[3:0] = {k[0], k[1], k[2], 1'b1};
    if (!k[2]) begin
      e[5:4] = {s[0], s[1]};
      e[21:17] = 5'h07;
    end else begin
      e[7:4] = {a[0], a[1], a[2], a[3]};
      e[21:17] = k[0] ? 5'h11 : 5'h09;
      for (int i = 0; i < 8; i++) e[8 + i] = k[0] & w[7 - i];
    end
    @(posedge clk_sys);
    #1;
    slow = 1'($random(seed));
    {req_kind, req_speed, req_addr, req_wdata} = {k, s, a, w};
    req_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    for (t = 0; t < 3000 && req_done !== 1'b1 && req_error !== 1'b1; t++) @(posedge clk_sys) #1;
    chk("finish", 22'h1, 22'(req_done | req_error));
    chk("refusal", 22'(bad), 22'(req_error));
    chk("stream", bad ? 22'h0 : e, q_cap.size() ? q_cap.pop_front() : 22'h0);
    if (k == 3'h4) begin
      for (t = 0; t < 50 && q_st.size() == 0; t++) @(posedge clk_sys);
      chk("status", 22'(a[1:0]), q_st.size() ? 22'(q_st.pop_front()) : 22'h3FFFFF);
    end
  endtask
  initial begin
    {rst, narrow_mode, req_valid, rx_go, slow} = 5'h10;
    {req_kind, req_speed, req_addr, req_wdata} = 17'h00000;
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int m = 0; m < 2; m++) begin
      narrow_mode = m[0];
      for (int k = 0; k < 8; k++) do_req(3'(k), 2'({$random(seed)} % 3));
    end
    do_req(3'h2, 2'h3);
    // A receive burst in mid-request loses it; the link must try again
    for (int k = 2; k < 4; k++) begin
      // Lane count settles in the link domain before any nibble arrives
      narrow_mode = k[0];
      repeat (2) @(posedge clk_sys);
      #1;
      rx_go = 1'b1;
      fork
        do_req(3'(k), 2'h1);
        begin
          repeat (40) @(posedge clk_sys);
          #1;
          rx_go = 1'b0;
        end
      join
    end
    print_verdict();
  end
  initial begin
    #4000000;
    failures++;
    print_verdict();
  end
endmodule // tb_link_to_phy_interface
`default_nettype wire
